/* File: logic/qdr_flash_end.sv */
`timescale 1ns/1ps
// Operation
// - host sets quad-line enable before quad read
// - address and data: nibble per edge
// - any start, increment per byte, wrap
// - single-line opcode, address, dummies, data
// - quad command: opcode nibble per clock
// - mode nibble A enters continuous read
// - other mode nibble leaves continuous read
// - read rejected while write cycle active
// - host gives enough dummies, floats low nibble
// - sector open takes address, low twelve ignored
// - only one sector open at once
// - opening only inside protected blocks
// - sector relock closes open sector
// - boot read prepared at reset
// - boot output waits start-delay count
// - quad enable picks boot timing
// - boot streams from start address
// - chip select rise ends boot read
// - boot read once per reset
// - boot settings kept non-volatile outside
module qdr_flash_end
   import qdr_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   qdr_link_if.dev LINK,
   input wire logic QUAD_LINES_ENABLE,
   input wire logic QUAD_COMMAND_MODE,
   input wire logic WRITE_CYCLE_ACTIVE,
   input wire logic [3:0] BLOCK_PROTECT,
   input wire logic TOP_BOTTOM_SELECT,
   input wire logic BOOT_READ_ENABLE,
   input wire logic [23:0] BOOT_START_ADDRESS,
   input wire logic [3:0] BOOT_START_DELAY,
   input wire logic [3:0] READ_DUMMY_CYCLES,
   output logic [23:0] MEM_ADDR,
   input wire logic [7:0] MEM_RDATA,
   input wire logic [23:0] PROG_ADDR,
   output logic PROG_PERMIT,
   output logic SECTOR_OPEN,
   output logic [11:0] SECTOR_INDEX,
   output logic CONTINUOUS_READ_MODE,
   output logic BOOT_ARMED
);
   typedef enum {D_IDLE, D_OPC, D_ADDR, D_DUMMY, D_DATA, D_DONE, D_DROP} qdr_dev_state_t;

   qdr_dev_state_t state_reg;
   logic sck_s1;
   logic sck_s2;
   logic sck_s3;
   logic cs_s1;
   logic cs_s2;
   logic cs_s3;
   logic [3:0] io_s1;
   logic [3:0] io_s2;
   logic [4:0] cnt_reg;
   logic [23:0] sreg_reg;
   logic [23:0] addr_reg;
   logic [7:0] op_reg;
   logic w4_reg;
   logic ddr_reg;
   logic boot_run_reg;
   logic [4:0] tgt_reg;
   logic [3:0] o_reg;
   logic oe_n_reg;
   logic [7:0] osh_reg;
   logic [2:0] oidx_reg;
   logic rise;
   logic fall;
   logic active;
   logic cs_fall;
   logic cs_rise;
   logic samp;
   logic [4:0] bits_next;
   logic [23:0] shifted;
   logic q_out;
   logic dum_last;
   logic launch;
   logic byte_end;
   logic [4:0] boot_tgt;

   assign LINK.dev_io_o = o_reg;
   assign LINK.dev_io_oe_n = oe_n_reg;
   assign MEM_ADDR = addr_reg;

   // link pins: two flops before any use
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end
      else if (CLK_EN)
      begin
         sck_s1 <= LINK.sck;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1 <= LINK.cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         io_s1 <= LINK.io;
         io_s2 <= io_s1;
      end

   // edge finding and phase decode
   always_comb
   begin
      rise = sck_s2 & ~sck_s3;
      fall = ~sck_s2 & sck_s3;
      active = ~cs_s2;
      cs_fall = ~cs_s2 & cs_s3;
      cs_rise = cs_s2 & ~cs_s3;
      // double rate: rise takes the upper nibble, fall the lower
      samp = (rise & ~(ddr_reg & cnt_reg[2])) | (fall & ddr_reg & cnt_reg[2]);
      bits_next = cnt_reg + (w4_reg ? 5'h04 : 5'h01);
      shifted = w4_reg ? {sreg_reg[19:0], io_s2} : {sreg_reg[22:0], io_s2[0]};
      q_out = boot_run_reg ? QUAD_LINES_ENABLE : 1'b1;
      dum_last = (cnt_reg + 5'h01) == tgt_reg;
      launch = active & ((state_reg == D_DATA & (fall | (rise & ~boot_run_reg)))
                         | (state_reg == D_DUMMY & fall & dum_last));
      byte_end = launch & (oidx_reg == (q_out ? 3'h1 : 3'h7));
      // boot wait: start delay on top of the chosen read's dummies
      boot_tgt = {1'b0, BOOT_START_DELAY}
                 + (QUAD_LINES_ENABLE ? {1'b0, READ_DUMMY_CYCLES} : QDR_FAST_DUMMY);
   end

   // command sequencer and address counter
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         state_reg <= D_IDLE;
         cnt_reg <= 5'h00;
         sreg_reg <= 24'h000000;
         addr_reg <= 24'h000000;
         op_reg <= QDR_BYTE_ZERO;
         w4_reg <= 1'b0;
         ddr_reg <= 1'b0;
         boot_run_reg <= 1'b0;
         tgt_reg <= 5'h00;
      end
      else if (CLK_EN)
      begin
         if (cs_s2)
         begin
            state_reg <= D_IDLE;
            boot_run_reg <= 1'b0;
         end
         else if (cs_fall)
         begin
            cnt_reg <= 5'h00;
            sreg_reg <= 24'h000000;
            ddr_reg <= 1'b0;
            if (BOOT_ARMED && BOOT_READ_ENABLE)
            begin
               boot_run_reg <= 1'b1;
               addr_reg <= BOOT_START_ADDRESS;
               tgt_reg <= boot_tgt;
               state_reg <= (boot_tgt == 5'h00) ? D_DATA : D_DUMMY;
            end
            else if (CONTINUOUS_READ_MODE)
            begin
               // no opcode: straight into the address phase
               op_reg <= QDR_OPC_QUAD_READ;
               w4_reg <= 1'b1;
               ddr_reg <= 1'b1;
               tgt_reg <= {1'b0, READ_DUMMY_CYCLES};
               state_reg <= WRITE_CYCLE_ACTIVE ? D_DROP : D_ADDR;
            end
            else
            begin
               w4_reg <= QUAD_COMMAND_MODE;
               state_reg <= D_OPC;
            end
         end
         else
         begin
            case (state_reg)
               D_OPC:
                  if (samp)
                  begin
                     sreg_reg <= shifted;
                     cnt_reg <= bits_next;
                     if (bits_next == QDR_BITS_OPC)
                     begin
                        cnt_reg <= 5'h00;
                        op_reg <= shifted[7:0];
                        case (shifted[7:0])
                           QDR_OPC_QUAD_READ:
                           begin
                              w4_reg <= 1'b1;
                              ddr_reg <= 1'b1;
                              tgt_reg <= {1'b0, READ_DUMMY_CYCLES};
                              state_reg <= WRITE_CYCLE_ACTIVE ? D_DROP : D_ADDR;
                           end
                           QDR_OPC_SECTOR_OPEN: state_reg <= D_ADDR;
                           QDR_OPC_SECTOR_RELOCK: state_reg <= D_DONE;
                           default: state_reg <= D_DROP;
                        endcase
                     end
                  end
               D_ADDR:
                  if (samp)
                  begin
                     sreg_reg <= shifted;
                     cnt_reg <= bits_next;
                     if (bits_next == QDR_BITS_ADDR)
                     begin
                        cnt_reg <= 5'h00;
                        ddr_reg <= 1'b0;
                        addr_reg <= shifted;
                        if (op_reg != QDR_OPC_QUAD_READ)
                           state_reg <= D_DONE;
                        else
                           state_reg <= (tgt_reg == 5'h00) ? D_DATA : D_DUMMY;
                     end
                  end
               D_DUMMY:
                  if (fall)
                  begin
                     cnt_reg <= cnt_reg + 5'h01;
                     if (dum_last)
                        state_reg <= D_DATA;
                  end
               D_DATA:
                  if (byte_end)
                     addr_reg <= addr_reg + QDR_ADDR_ONE;
               default: state_reg <= state_reg;
            endcase
         end
      end

   // data out: first chunk of a byte straight from the array
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         o_reg <= 4'h0;
         oe_n_reg <= 1'b1;
         osh_reg <= 8'h00;
         oidx_reg <= 3'h0;
      end
      else if (CLK_EN)
      begin
         if (!active)
         begin
            oe_n_reg <= 1'b1;
            oidx_reg <= 3'h0;
         end
         else if (launch)
         begin
            oe_n_reg <= 1'b0;
            if (oidx_reg == 3'h0)
            begin
               o_reg <= qdr_chunk(MEM_RDATA, q_out);
               osh_reg <= qdr_shift_out(MEM_RDATA, q_out);
            end
            else
            begin
               o_reg <= qdr_chunk(osh_reg, q_out);
               osh_reg <= qdr_shift_out(osh_reg, q_out);
            end
            oidx_reg <= byte_end ? 3'h0 : oidx_reg + 3'h1;
         end
         else if (state_reg != D_DATA)
            oe_n_reg <= 1'b1; // lines stay free through dummies
      end

   // mode nibble on the first dummy rise decides the next read's form
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
         CONTINUOUS_READ_MODE <= 1'b0;
      else if (CLK_EN && state_reg == D_DUMMY && !boot_run_reg && rise && cnt_reg == 5'h00)
         CONTINUOUS_READ_MODE <= io_s2 == QDR_CONT_NIBBLE;

   // boot armed by reset, spent when the boot burst's select rises
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
         BOOT_ARMED <= 1'b1;
      else if (CLK_EN && cs_rise && boot_run_reg)
         BOOT_ARMED <= 1'b0;

   // single open sector, acted on when select rises after a whole command
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         SECTOR_OPEN <= 1'b0;
         SECTOR_INDEX <= 12'h000;
      end
      else if (CLK_EN && cs_rise && state_reg == D_DONE)
      begin
         if (op_reg == QDR_OPC_SECTOR_RELOCK)
            SECTOR_OPEN <= 1'b0;
         else if (op_reg == QDR_OPC_SECTOR_OPEN && !SECTOR_OPEN
                  && qdr_protected(addr_reg, BLOCK_PROTECT, TOP_BOTTOM_SELECT))
         begin
            SECTOR_OPEN <= 1'b1;
            SECTOR_INDEX <= addr_reg[QDR_ADDR_W-1:QDR_SECTOR_LSB];
         end
      end

   // write permission: unprotected, or the one open sector
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
         PROG_PERMIT <= 1'b0;
      else if (CLK_EN)
         PROG_PERMIT <= !qdr_protected(PROG_ADDR, BLOCK_PROTECT, TOP_BOTTOM_SELECT)
                        || (SECTOR_OPEN
                            && PROG_ADDR[QDR_ADDR_W-1:QDR_SECTOR_LSB] == SECTOR_INDEX);
endmodule // qdr_flash_end

/* File: logic/qdr_pkg.sv */
package qdr_pkg;
   // opcodes
   localparam logic [7:0] QDR_OPC_QUAD_READ = 8'hED;
   localparam logic [7:0] QDR_OPC_SECTOR_OPEN = 8'h26;
   localparam logic [7:0] QDR_OPC_SECTOR_RELOCK = 8'h24;
   localparam logic [7:0] QDR_BYTE_ZERO = 8'h00;
   // address layout
   localparam int QDR_ADDR_W = 24;
   localparam int QDR_SECTOR_LSB = 12;
   localparam int QDR_BLOCK_LSB = 16;
   localparam int QDR_SECT_W = QDR_ADDR_W - QDR_SECTOR_LSB;
   localparam logic [8:0] QDR_NUM_BLK = 9'h100;
   localparam logic [23:0] QDR_ADDR_ONE = 24'h000001;
   // phase sizes in bits and cycles
   localparam logic [4:0] QDR_BITS_OPC = 5'h08;
   localparam logic [4:0] QDR_BITS_ADDR = 5'h18;
   localparam logic [3:0] QDR_QUAD_DUMMY_DEF = 4'h6;
   localparam logic [4:0] QDR_FAST_DUMMY = 5'h08;
   localparam logic [3:0] QDR_CONT_NIBBLE = 4'hA;
   localparam logic [3:0] QDR_EXIT_NIBBLE = 4'h0;
   localparam logic [3:0] QDR_PULL_LEVEL = 4'hF;
   // host-made link clock: half period as a least time, rounded up
   localparam int QDR_CLK_NS = 10;
   localparam int QDR_LINK_HALF_NS = 80;
   localparam int QDR_HALF_CYC = (QDR_LINK_HALF_NS + QDR_CLK_NS - 1) / QDR_CLK_NS;
   localparam logic [3:0] QDR_HALF_LAST = 4'(QDR_HALF_CYC - 1);
   localparam logic [3:0] QDR_HALF_MID = 4'(QDR_HALF_CYC / 2 - 1);

   typedef enum logic [1:0] {QDR_CMD_READ, QDR_CMD_OPEN, QDR_CMD_RELOCK, QDR_CMD_BOOT} qdr_cmd_t;

   // block lies in the region fenced by the protect bits (tbs low: top)
   function automatic logic qdr_protected(input logic [23:0] a, input logic [3:0] bp,
                                          input logic top_bottom_select);
      logic [8:0] nblk;
      logic [8:0] blk;
      blk = {1'b0, a[QDR_ADDR_W-1:QDR_BLOCK_LSB]};
      if (bp == 4'h0)
         nblk = 9'h000;
      else if (bp >= 4'h9)
         nblk = QDR_NUM_BLK;
      else
         nblk = 9'(9'h001 << (bp - 4'h1));
      return top_bottom_select ? (blk < nblk) : (blk >= QDR_NUM_BLK - nblk);
   endfunction

   // top chunk of a byte: nibble on all lines, or one bit on line 1
   function automatic logic [3:0] qdr_chunk(input logic [7:0] b, input logic q);
      return q ? b[7:4] : {2'h0, b[7], 1'b0};
   endfunction

   function automatic logic [7:0] qdr_shift_out(input logic [7:0] b, input logic q);
      return q ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] qdr_shift_in(input logic [7:0] b, input logic [3:0] io,
                                               input logic q);
      return q ? {b[3:0], io} : {b[6:0], io[1]};
   endfunction

   // link edges needed to move a number of bits
   function automatic logic [11:0] qdr_edges(input logic [11:0] bits, input logic w4,
                                             input logic ddr);
      logic [11:0] n;
      n = w4 ? (bits >> 2) : bits;
      return ddr ? n : 12'(n << 1);
   endfunction
endpackage

/* File: logic/qdr_link_if.sv */
`timescale 1ns/1ps
interface qdr_link_if;
   logic sck;
   logic cs_n;
   logic [3:0] host_io_o;
   logic host_io_oe_n;
   logic [3:0] dev_io_o;
   logic dev_io_oe_n;
   logic [3:0] io;

   // resolved line level; released lines float to the pull level
   assign io = !dev_io_oe_n ? dev_io_o : (!host_io_oe_n ? host_io_o : 4'hF);

   modport dev(input sck, input cs_n, input io, output dev_io_o, output dev_io_oe_n);
   modport host(output sck, output cs_n, output host_io_o, output host_io_oe_n, input io);
endinterface

/* File: logic/qdr_host_end.sv */
`timescale 1ns/1ps
module qdr_host_end
   import qdr_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   qdr_link_if.host LINK,
   input wire logic START,
   input wire qdr_cmd_t CMD,
   input wire logic QUAD_COMMAND_MODE,
   input wire logic CONT_ACTIVE,
   input wire logic CONT_REQ,
   input wire logic [23:0] ADDR,
   input wire logic [3:0] DUMMY_CYCLES,
   input wire logic [7:0] NBYTES,
   input wire logic BOOT_QUAD,
   input wire logic [4:0] BOOT_WAIT_CYCLES,
   output logic BUSY,
   output logic [7:0] RDATA,
   output logic RVALID,
   output logic DONE
);
   typedef enum {H_IDLE, H_OPC, H_ADDR, H_DUM, H_DATA, H_END} qdr_host_state_t;

   qdr_host_state_t state_reg;
   qdr_cmd_t cmd_reg;
   logic [3:0] hcnt_reg;
   logic sck_reg;
   logic cs_n_reg;
   logic [3:0] o_reg;
   logic oe_n_reg;
   logic [31:0] osh_reg;
   logic [11:0] ecnt_reg;
   logic qcm_reg;
   logic bq_reg;
   logic [3:0] mode_reg;
   logic [4:0] tgt_reg;
   logic [7:0] nbytes_reg;
   logic [7:0] rsh_reg;
   logic [2:0] rcnt_reg;
   logic [3:0] io_s1;
   logic [3:0] io_s2;
   logic tick;
   logic mid;
   logic up_rise;
   logic is_read;
   logic w4;
   logic ddr;
   logic dq;
   logic [11:0] len;
   logic samp;
   logic edge_last;
   logic [7:0] rsh_next;

   assign LINK.sck = sck_reg;
   assign LINK.cs_n = cs_n_reg;
   assign LINK.host_io_o = o_reg;
   assign LINK.host_io_oe_n = oe_n_reg;
   assign BUSY = state_reg != H_IDLE;

   // phase decode; read address and data move on both edges
   always_comb
   begin
      tick = hcnt_reg == QDR_HALF_LAST;
      mid = hcnt_reg == QDR_HALF_MID;
      up_rise = ~sck_reg;
      is_read = cmd_reg == QDR_CMD_READ;
      w4 = (is_read & state_reg != H_OPC) | qcm_reg;
      ddr = is_read & (state_reg == H_ADDR | state_reg == H_DATA);
      dq = (cmd_reg == QDR_CMD_BOOT) ? bq_reg : 1'b1;
      case (state_reg)
         H_OPC: len = qdr_edges({7'h00, QDR_BITS_OPC}, w4, 1'b0);
         H_ADDR: len = qdr_edges({7'h00, QDR_BITS_ADDR}, w4, ddr);
         H_DUM: len = qdr_edges({7'h00, tgt_reg}, 1'b0, 1'b0);
         H_DATA: len = qdr_edges({1'b0, nbytes_reg, 3'h0}, dq, ddr);
         default: len = 12'h000;
      endcase
      samp = tick & state_reg == H_DATA & (up_rise | ddr);
      edge_last = tick & (ecnt_reg + 12'h001 == len);
      rsh_next = qdr_shift_in(rsh_reg, io_s2, dq);
   end

   // return lines come from the far end's domain
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end
      else if (CLK_EN)
      begin
         io_s1 <= LINK.io;
         io_s2 <= io_s1;
      end

   // sequencer: clock divider, phases and line drive
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         state_reg <= H_IDLE;
         cmd_reg <= QDR_CMD_READ;
         hcnt_reg <= 4'h0;
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         o_reg <= QDR_PULL_LEVEL;
         oe_n_reg <= 1'b1;
         osh_reg <= 32'h00000000;
         ecnt_reg <= 12'h000;
         qcm_reg <= 1'b0;
         bq_reg <= 1'b0;
         mode_reg <= QDR_EXIT_NIBBLE;
         tgt_reg <= 5'h00;
         nbytes_reg <= 8'h00;
         DONE <= 1'b0;
      end
      else if (CLK_EN)
      begin
         DONE <= 1'b0;
         if (state_reg == H_IDLE)
         begin
            if (START)
            begin
               cmd_reg <= CMD;
               qcm_reg <= QUAD_COMMAND_MODE;
               bq_reg <= BOOT_QUAD;
               mode_reg <= CONT_REQ ? QDR_CONT_NIBBLE : QDR_EXIT_NIBBLE;
               nbytes_reg <= NBYTES;
               hcnt_reg <= 4'h0;
               ecnt_reg <= 12'h000;
               cs_n_reg <= 1'b0;
               if (CMD == QDR_CMD_BOOT)
               begin
                  tgt_reg <= BOOT_WAIT_CYCLES;
                  state_reg <= H_DUM;
               end
               else
               begin
                  tgt_reg <= {1'b0, DUMMY_CYCLES};
                  if (CMD == QDR_CMD_READ && CONT_ACTIVE)
                  begin
                     osh_reg <= {ADDR, QDR_BYTE_ZERO};
                     state_reg <= H_ADDR;
                  end
                  else
                  begin
                     case (CMD)
                        QDR_CMD_OPEN: osh_reg <= {QDR_OPC_SECTOR_OPEN, ADDR};
                        QDR_CMD_RELOCK: osh_reg <= {QDR_OPC_SECTOR_RELOCK, 24'h000000};
                        default: osh_reg <= {QDR_OPC_QUAD_READ, ADDR};
                     endcase
                     state_reg <= H_OPC;
                  end
               end
            end
         end
         else
         begin
            hcnt_reg <= tick ? 4'h0 : hcnt_reg + 4'h1;
            if (state_reg == H_END)
            begin
               if (tick)
               begin
                  cs_n_reg <= 1'b1;
                  DONE <= 1'b1;
                  state_reg <= H_IDLE;
               end
            end
            else if (tick)
            begin
               sck_reg <= ~sck_reg;
               ecnt_reg <= ecnt_reg + 12'h001;
               if (edge_last)
               begin
                  ecnt_reg <= 12'h000;
                  case (state_reg)
                     H_OPC: state_reg <= (cmd_reg == QDR_CMD_RELOCK) ? H_END : H_ADDR;
                     H_ADDR: state_reg <= !is_read ? H_END : (tgt_reg == 5'h00 ? H_DATA : H_DUM);
                     H_DUM: state_reg <= H_DATA;
                     default: state_reg <= H_END;
                  endcase
               end
            end
            // new values mid-way between edges so the far end never races them
            if (mid)
            begin
               if ((state_reg == H_OPC | state_reg == H_ADDR) & (up_rise | ddr))
               begin
                  o_reg <= w4 ? osh_reg[31:28] : {QDR_PULL_LEVEL[3:1], osh_reg[31]};
                  osh_reg <= w4 ? {osh_reg[27:0], 4'h0} : {osh_reg[30:0], 1'b0};
                  oe_n_reg <= 1'b0;
               end
               else if (state_reg == H_DUM & ecnt_reg == 12'h000 & cmd_reg != QDR_CMD_BOOT)
               begin
                  o_reg <= mode_reg;
                  oe_n_reg <= 1'b0;
               end
               else
                  oe_n_reg <= 1'b1;
            end
         end
      end

   // read capture: upper nibble at the rise, lower at the fall; boot data is taken at rises only
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B)
      begin
         rsh_reg <= 8'h00;
         rcnt_reg <= 3'h0;
         RDATA <= 8'h00;
         RVALID <= 1'b0;
      end
      else if (CLK_EN)
      begin
         RVALID <= 1'b0;
         if (state_reg == H_IDLE)
            rcnt_reg <= 3'h0;
         else if (samp)
         begin
            rsh_reg <= rsh_next;
            rcnt_reg <= rcnt_reg + 3'h1;
            if (rcnt_reg == (dq ? 3'h1 : 3'h7))
            begin
               rcnt_reg <= 3'h0;
               RDATA <= rsh_next;
               RVALID <= 1'b1;
            end
         end
      end
endmodule // qdr_host_end

/* File: verification/qdr_link_checker.sv */
`timescale 1ns/1ps
module qdr_link_checker (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] host_io_o,
   input wire logic host_io_oe_n,
   input wire logic [3:0] dev_io_o,
   input wire logic dev_io_oe_n
);
   // whole link lives in the system clock domain
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   AST_NO_CONTENTION: assert property (dev_io_oe_n || host_io_oe_n)
      else $error("both ends drive io");
   AST_DEV_QUIET: assert property (cs_n [*5] |-> dev_io_oe_n)
      else $error("device drives when deselected");
   AST_SCK_IN_FRAME: assert property ($rose(sck) |-> !cs_n)
      else $error("clock edge outside frame");
   AST_HIGH_HALF: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
      else $error("clock high half wrong");
   AST_LOW_HALF: assert property ($fell(sck) |-> (!sck) [*8])
      else $error("clock low half short");
   AST_HOST_HOLD: assert property ($changed(sck) && !host_io_oe_n |-> ##1 $stable(host_io_o))
      else $error("host data moved at edge");
   AST_DEV_HOLD: assert property ($changed(sck) && !dev_io_oe_n |-> $stable(dev_io_o))
      else $error("device data moved at edge");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("deselect gap short");
endmodule // qdr_link_checker

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb_top;
   import qdr_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   logic qcm = 1'b0;
   logic cont = 1'b0;
   logic creq = 1'b0;
   logic write_cycle_active = 1'b0;
   // link settings: clk_en, qe and dummy shared by both ends, so each pair agrees; bp and top_bottom_select feed the device only
   logic clk_en = 1'b1;
   logic qe = 1'b1;
   logic top_bottom_select = 1'b0;
   logic [3:0] dummy = 4'h6;
   logic [3:0] bp = 4'h1;
   qdr_cmd_t cmd = QDR_CMD_READ;
   logic [23:0] addr = 24'h000000;
   logic [23:0] prog_addr = 24'h000000;
   logic [7:0] nbytes = 8'h01;
   logic [23:0] mem_addr;
   logic [11:0] sect_idx;
   logic [7:0] rdata;
   logic rvalid, done, prog_ok, sect_open, cont_mode, boot_armed;
   int n_fail = 0;
   int comparisons = 0;
   int n_done = 0;
   logic [7:0] got [$];
   // array content mixes all address bytes, so a wrap or missed increment shows
   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h3C;
   endfunction
   always #5 clk = ~clk;
   qdr_link_if i_qdr_link_if();
   qdr_host_end i_qdr_host_end(.CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .LINK(i_qdr_link_if),
      .START(start), .CMD(cmd), .QUAD_COMMAND_MODE(qcm), .CONT_ACTIVE(cont), .CONT_REQ(creq),
      .ADDR(addr), .DUMMY_CYCLES(dummy), .NBYTES(nbytes), .BOOT_QUAD(qe),
      .BOOT_WAIT_CYCLES(5'h08), .BUSY(), .RDATA(rdata), .RVALID(rvalid), .DONE(done));
   qdr_flash_end i_qdr_flash_end(.CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .LINK(i_qdr_link_if),
      .QUAD_LINES_ENABLE(qe), .QUAD_COMMAND_MODE(qcm), .WRITE_CYCLE_ACTIVE(write_cycle_active),
      .BLOCK_PROTECT(bp), .TOP_BOTTOM_SELECT(top_bottom_select), .BOOT_READ_ENABLE(1'b1),
      .BOOT_START_ADDRESS(24'h0ABCDE), .BOOT_START_DELAY(4'h2), .READ_DUMMY_CYCLES(dummy),
      .MEM_ADDR(mem_addr), .MEM_RDATA(mem(mem_addr)), .PROG_ADDR(prog_addr),
      .PROG_PERMIT(prog_ok), .SECTOR_OPEN(sect_open), .SECTOR_INDEX(sect_idx),
      .CONTINUOUS_READ_MODE(cont_mode), .BOOT_ARMED(boot_armed));
   qdr_link_checker i_qdr_link_checker(.CLK(clk), .RST_B(rst_b), .sck(i_qdr_link_if.sck),
      .cs_n(i_qdr_link_if.cs_n), .host_io_o(i_qdr_link_if.host_io_o),
      .host_io_oe_n(i_qdr_link_if.host_io_oe_n), .dev_io_o(i_qdr_link_if.dev_io_o),
      .dev_io_oe_n(i_qdr_link_if.dev_io_oe_n));
   // collect read bytes and count completions
   always @(posedge clk)
   begin
      if (rvalid) got.push_back(rdata);
      if (done) n_done++;
   end
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // one transfer; the wait stops at the first done pulse
   task automatic op(input qdr_cmd_t c, input logic [23:0] a, input logic [7:0] n);
      int k;
      k = n_done;
      got.delete();
      cmd <= c;
      addr <= a;
      nbytes <= n;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (20000) if (n_done == k) @(posedge clk);
      `CHK(n_done != k, 1'b1)
      // device status settles a few cycles after deselect
      repeat (12) @(posedge clk);
   endtask
   task automatic chk_data(input logic [23:0] a, input int n);
      `CHK(got.size(), n)
      for (int k = 0; k < n; k++) `CHK(got[k], mem(a + 24'(k)))
   endtask
   task automatic t_boot();
      `CHK(boot_armed, 1'b1)
      op(QDR_CMD_BOOT, 24'h000000, 8'h03);
      chk_data(24'h0ABCDE, 3);
      `CHK(boot_armed, 1'b0)
   endtask
   task automatic t_spi_wrap();
      creq <= 1'b1;
      op(QDR_CMD_READ, 24'hFFFFFE, 8'h04);
      chk_data(24'hFFFFFE, 4);
      `CHK(cont_mode, 1'b1)
   endtask
   task automatic t_cont_quad();
      cont <= 1'b1;
      creq <= 1'b0;
      op(QDR_CMD_READ, 24'h123456, 8'h02);
      chk_data(24'h123456, 2);
      `CHK(cont_mode, 1'b0)
      cont <= 1'b0;
      qcm <= 1'b1;
      op(QDR_CMD_READ, 24'h00ABCD, 8'h02);
      chk_data(24'h00ABCD, 2);
      qcm <= 1'b0;
   endtask
   task automatic t_busy_reject();
      write_cycle_active <= 1'b1;
      op(QDR_CMD_READ, 24'h000000, 8'h02);
      `CHK(got[0], 8'hFF)
      write_cycle_active <= 1'b0;
   endtask
   task automatic t_sector();
      op(QDR_CMD_OPEN, 24'hFF3ABC, 8'h01);
      `CHK({sect_open, sect_idx}, 13'h1FF3)
      prog_addr <= 24'hFF3123;
      repeat (2) @(posedge clk);
      `CHK(prog_ok, 1'b1)
      prog_addr <= 24'hFF4000;
      repeat (2) @(posedge clk);
      `CHK(prog_ok, 1'b0)
      op(QDR_CMD_OPEN, 24'hFF5000, 8'h01);
      `CHK(sect_idx, 12'hFF3)
      op(QDR_CMD_RELOCK, 24'h000000, 8'h01);
      `CHK(sect_open, 1'b0)
      op(QDR_CMD_OPEN, 24'h001000, 8'h01);
      `CHK(sect_open, 1'b0)
      op(QDR_CMD_OPEN, 24'hFF5000, 8'h01);
      `CHK({sect_open, sect_idx}, 13'h1FF5)
      // protection off: every address writable again
      bp <= 4'h0;
      repeat (2) @(posedge clk);
      `CHK(prog_ok, 1'b1)
      // bottom region with one block: top block free, block 0 fenced
      bp <= 4'h1;
      top_bottom_select <= 1'b1;
      prog_addr <= 24'h000123;
      repeat (2) @(posedge clk);
      `CHK(prog_ok, 1'b0)
      top_bottom_select <= 1'b0;
   endtask
   // main sequence: boot must come first, right after reset
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_boot();
      t_spi_wrap();
      t_cont_quad();
      t_busy_reject();
      t_sector();
      stop_test();
   end
   // watchdog, far above the few thousand cycles the run needs
   initial
   begin
      #900000;
      n_fail++;
      stop_test();
   end
endmodule // tb_top
